// ===== src/vlink_cfg_pkg.sv
// Purpose: constants for the virtual-side link configuration register bank
// Assumes: dword-addressed configuration accesses, byte offsets as printed
// Notes:   field positions and reset values are named once here
package vlink_cfg_pkg;
    // offsets
    localparam logic [11:0] off_link_capability            = 12'h074;
    localparam logic [11:0] off_link_status_control        = 12'h078;
    localparam logic [11:0] off_link_status_control_second = 12'h098;
    localparam logic [11:0] off_subsystem_cap_header       = 12'h0A4;
    localparam logic [11:0] off_vendor_cap_three_header    = 12'h0C8;
    localparam logic [11:0] off_vendor_cap_three_extra     = 12'h0CC;
    localparam logic [11:0] off_virtual_bar_zero_one_setup = 12'h0D0;
    localparam logic [11:0] off_cursor_address             = 12'h0F8;
    localparam logic [11:0] off_cursor_data                = 12'h0FC;
    localparam logic [11:0] off_extended_base              = 12'h100;
    // speed codes
    localparam logic [3:0] speed_gen1      = 4'h1;
    localparam logic [3:0] speed_gen2      = 4'h2;
    // link capability values
    localparam logic [1:0] aspm_support_rst = 2'h1;
    localparam logic [2:0] l0s_exit_gen2    = 3'h4;
    localparam logic [2:0] l0s_exit_gen1    = 3'h5;
    localparam logic [2:0] l1_exit_gen2     = 3'h1;
    localparam logic [2:0] l1_exit_gen1     = 3'h2;
    localparam logic [5:0] width_x1         = 6'h01;
    localparam logic [5:0] width_x16        = 6'h10;
    localparam logic [5:0] width_down       = 6'h00;
    // link control write masks: aspm 1:0, common clock 6, extended sync 7
    localparam logic [15:0] link_control_mask  = 16'h00C3;
    localparam int          common_clock_bit   = 6;
    // second control: speed 3:0, compliance 4, margin 9:7, mod 10, skp 11, deemph 12
    localparam logic [15:0] link_control2_mask = 16'h1F9F;
    localparam logic [15:0] link_control2_rst  = 16'h0002;
    localparam int          enter_compliance_bit = 4;
    localparam int          compliance_skp_bit   = 11;
    localparam int          compliance_deemph_bit = 12;
    // capability headers
    localparam logic [7:0] subsys_cap_id       = 8'h0D;
    localparam logic [7:0] subsys_next_ptr     = 8'hC8;
    localparam logic [7:0] vendor_cap_id       = 8'h09;
    localparam logic [7:0] vendor_next_ptr     = 8'h00;
    localparam logic [7:0] vendor_cap_length   = 8'h38;
    localparam logic [31:0] vendor_extra_rst   = 32'h03800002;
    // virtual_bar_zero_one_setup codes
    localparam logic [1:0] bar_disabled        = 2'h0;
    localparam logic [1:0] bar_reserved        = 2'h1;
    localparam logic [1:0] bar_32bit           = 2'h2;
    localparam logic [1:0] bar_64bit           = 2'h3;
    // cursor address: offset 25:16, select 31
    localparam logic [31:0] cursor_addr_mask   = 32'h83FF0000;
    // l0s exit time symbol scale (ns per symbol) and symbols per fts
    localparam int          symbols_per_fts    = 4;
    localparam int          symbol_ns_gen1     = 4;
    localparam int          symbol_ns_gen2     = 2;
    // l0s exit encoding thresholds in ns
    localparam int          l0s_thr_code4_ns   = 512;
    localparam int          l0s_thr_code5_ns   = 1000;
    localparam int          l0s_thr_code6_ns   = 2000;
endpackage

// ===== src/virtual_side_link_config_regs.sv
// Purpose: virtual-side link configuration registers of a non-transparent port
// Assumes: single-cycle configuration read/write port, straps held stable at reset
// Notes:   reads answer one clock after the request
`timescale 1ns/10ps
module virtual_side_link_config_regs #(
    parameter int nfts_width = 8
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // strap balls (asynchronous levels)
    input  wire logic                  speed_select_strap,
    input  wire logic [4:0]            station_lane_config_straps,
    input  wire logic [3:0]            nontransparent_port_select_straps,
    // serial-memory preload
    input  wire logic                  preload_valid,
    input  wire logic [5:0]            preload_max_width,
    input  wire logic [7:0]            preload_subsys_cap_id,
    input  wire logic [7:0]            preload_subsys_next_ptr,
    // physical layer state
    input  wire logic                  link_up,
    input  wire logic                  link_at_gen2,
    input  wire logic [5:0]            link_width,
    input  wire logic [nfts_width-1:0] sync_nfts,
    input  wire logic [nfts_width-1:0] async_nfts,
    // configuration access
    input  wire logic                  cfg_req,
    input  wire logic                  cfg_write,
    input  wire logic [11:0]           cfg_addr,
    input  wire logic [31:0]           cfg_wdata,
    input  wire logic [3:0]            cfg_be,
    output logic                       cfg_ack,
    output logic [31:0]                cfg_rdata,
    // cursor access to extended space
    output logic                       ext_req,
    output logic                       ext_write,
    output logic                       ext_select_virtual,
    output logic [11:0]                ext_addr,
    output logic [31:0]                ext_wdata,
    output logic                       ext_device_specific_ok,
    input  wire logic [31:0]           ext_rdata,
    // controls to the training state machine
    output logic                       ltssm_insert_skp,
    output logic                       ltssm_compliance_deemph,
    output logic                       ltssm_compliance_deemph_valid,
    output logic [1:0]                 bar_zero_one_mode,
    output logic [nfts_width+4:0]      l0s_exit_ns
);

    // ****************************************
    // strap synchronisers and capture
    // ****************************************
    logic [9:0] strap_meta;
    logic [9:0] strap_sync;
    logic       strap_captured;
    logic       speed_strap;
    logic [5:0] max_width;
    logic [7:0] port_number;
    logic [7:0] subsys_id;
    logic [7:0] subsys_next;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strap_meta <= 10'h000;
            strap_sync <= 10'h000;
        end else begin
            strap_meta <= {speed_select_strap, station_lane_config_straps,
                           nontransparent_port_select_straps};
            strap_sync <= strap_meta;
        end
    end

    function automatic logic [5:0] lane_width(input logic [4:0] cfg);
        logic [5:0] w;
        w = vlink_cfg_pkg::width_x1;
        case (cfg[2:0])
            3'h0:    w = vlink_cfg_pkg::width_x16;
            3'h1:    w = 6'h08;
            3'h2:    w = 6'h04;
            3'h3:    w = 6'h02;
            default: w = vlink_cfg_pkg::width_x1;
        endcase
        return w;
    endfunction

    // straps are caught a few clocks after release, once the synchroniser settled
    logic [1:0] capture_wait;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            capture_wait   <= 2'h0;
            strap_captured <= 1'b0;
            speed_strap    <= 1'b0;
            max_width      <= vlink_cfg_pkg::width_x16;
            port_number    <= 8'h00;
            subsys_id      <= vlink_cfg_pkg::subsys_cap_id;
            subsys_next    <= vlink_cfg_pkg::subsys_next_ptr;
        end else begin
            if (capture_wait != 2'h3) begin
                capture_wait <= capture_wait + 2'h1;
            end
            if (capture_wait == 2'h2 && !strap_captured) begin
                strap_captured <= 1'b1;
                speed_strap    <= strap_sync[9];
                max_width      <= lane_width(strap_sync[8:4]);
                port_number    <= {4'h0, strap_sync[3], 3'h0} |
                                  {5'h00, strap_sync[2:0]};
            end else if (preload_valid) begin
                max_width   <= preload_max_width;
                subsys_id   <= preload_subsys_cap_id;
                subsys_next <= preload_subsys_next_ptr;
            end
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    logic [31:0] be_mask;
    logic        wr_any;
    assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    assign wr_any  = cfg_req && cfg_write;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] mask);
        return (old & ~mask) | (wd & mask);
    endfunction

    // ****************************************
    // writable fields
    // ****************************************
    logic [15:0] link_control;
    logic [15:0] link_control2;
    logic [1:0]  bar_mode;
    logic [31:0] cursor_addr;
    logic [15:0] lc_mask;
    logic [15:0] lc2_mask;

    // only the storable bits of each byte lane that is enabled
    assign lc_mask  = be_mask[15:0] & vlink_cfg_pkg::link_control_mask;
    assign lc2_mask = be_mask[15:0] & vlink_cfg_pkg::link_control2_mask;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            link_control <= 16'h0000;
        end else if (wr_any && cfg_addr == vlink_cfg_pkg::off_link_status_control) begin
            link_control <= (link_control & ~lc_mask)
                            | (cfg_wdata[15:0] & lc_mask);
        end
    end

    // sticky: only the fundamental reset clears it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            link_control2 <= vlink_cfg_pkg::link_control2_rst;
        end else if (wr_any && cfg_addr == vlink_cfg_pkg::off_link_status_control_second) begin
            link_control2 <= (link_control2 & ~lc2_mask)
                             | (cfg_wdata[15:0] & lc2_mask);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bar_mode <= vlink_cfg_pkg::bar_32bit;
        end else if (wr_any && cfg_be[0]
                     && cfg_addr == vlink_cfg_pkg::off_virtual_bar_zero_one_setup
                     && cfg_wdata[1:0] != vlink_cfg_pkg::bar_reserved) begin
            bar_mode <= cfg_wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cursor_addr <= 32'h00000000;
        end else if (wr_any && cfg_addr == vlink_cfg_pkg::off_cursor_address) begin
            cursor_addr <= merge(cursor_addr, cfg_wdata,
                                 be_mask & vlink_cfg_pkg::cursor_addr_mask);
        end
    end

    // ****************************************
    // derived status
    // ****************************************
    logic [3:0]            supported_speeds;
    logic [3:0]            current_speed;
    logic [5:0]            neg_width;
    logic [nfts_width-1:0] nfts_sel;
    logic [nfts_width+4:0] next_l0s_ns;
    logic [2:0]            l0s_code;
    logic [2:0]            l1_code;
    logic                  gen2_now;

    assign supported_speeds = speed_strap ? vlink_cfg_pkg::speed_gen2
                                          : vlink_cfg_pkg::speed_gen1;
    assign gen2_now      = link_up && link_at_gen2 && speed_strap;
    assign current_speed = gen2_now ? vlink_cfg_pkg::speed_gen2
                                    : vlink_cfg_pkg::speed_gen1;
    assign neg_width     = link_up ? link_width : vlink_cfg_pkg::width_down;
    assign nfts_sel      = link_control[vlink_cfg_pkg::common_clock_bit]
                           ? sync_nfts : async_nfts;
    // count x 4 symbols x 2 or 4 ns, i.e. a shift by 3 or 4
    assign next_l0s_ns   = gen2_now ? {2'b00, nfts_sel, 3'b000}
                                    : {1'b0, nfts_sel, 4'h0};
    assign l0s_code      = gen2_now ? vlink_cfg_pkg::l0s_exit_gen2
                                    : vlink_cfg_pkg::l0s_exit_gen1;
    assign l1_code       = gen2_now ? vlink_cfg_pkg::l1_exit_gen2
                                    : vlink_cfg_pkg::l1_exit_gen1;

    // ****************************************
    // read mux
    // ****************************************
    logic [31:0] next_rdata;
    logic        cursor_hit;
    logic        cursor_dev_ok;

    assign cursor_dev_ok = port_number == 8'h00;
    assign cursor_hit    = cfg_req && cfg_addr == vlink_cfg_pkg::off_cursor_data;

    always_comb begin
        next_rdata = 32'h00000000;
        case (cfg_addr)
            vlink_cfg_pkg::off_link_capability:
                next_rdata = {port_number, 5'h00, 1'b0, l1_code, l0s_code,
                              vlink_cfg_pkg::aspm_support_rst, max_width,
                              supported_speeds};
            vlink_cfg_pkg::off_link_status_control:
                next_rdata = {3'h0, 1'b0, 1'b0, 1'b0, neg_width, current_speed,
                              link_control};
            vlink_cfg_pkg::off_link_status_control_second:
                next_rdata = {15'h0000, ~gen2_now, link_control2};
            vlink_cfg_pkg::off_subsystem_cap_header:
                next_rdata = {16'h0000, subsys_next, subsys_id};
            vlink_cfg_pkg::off_vendor_cap_three_header:
                next_rdata = {8'h00, vlink_cfg_pkg::vendor_cap_length,
                              vlink_cfg_pkg::vendor_next_ptr,
                              vlink_cfg_pkg::vendor_cap_id};
            vlink_cfg_pkg::off_vendor_cap_three_extra:
                next_rdata = vlink_cfg_pkg::vendor_extra_rst;
            vlink_cfg_pkg::off_virtual_bar_zero_one_setup:
                next_rdata = {30'h00000000, bar_mode};
            vlink_cfg_pkg::off_cursor_address:
                next_rdata = cursor_addr;
            vlink_cfg_pkg::off_cursor_data:
                next_rdata = ext_rdata;
            default:
                next_rdata = 32'h00000000;
        endcase
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            cfg_ack   <= cfg_req;
            cfg_rdata <= (cfg_req && !cfg_write) ? next_rdata : 32'h00000000;
        end
    end

    // extended address = cursor dword offset x 4
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ext_req                <= 1'b0;
            ext_write              <= 1'b0;
            ext_select_virtual     <= 1'b0;
            ext_addr               <= 12'h000;
            ext_wdata              <= 32'h00000000;
            ext_device_specific_ok <= 1'b0;
        end else begin
            ext_req                <= cursor_hit;
            ext_write              <= cursor_hit && cfg_write;
            ext_select_virtual     <= cursor_addr[31];
            ext_addr               <= {cursor_addr[25:16], 2'b00};
            ext_wdata              <= cfg_wdata;
            ext_device_specific_ok <= cursor_dev_ok;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ltssm_insert_skp              <= 1'b0;
            ltssm_compliance_deemph       <= 1'b0;
            ltssm_compliance_deemph_valid <= 1'b0;
            bar_zero_one_mode             <= vlink_cfg_pkg::bar_32bit;
            l0s_exit_ns                   <= '0;
        end else begin
            ltssm_insert_skp <= link_control2[vlink_cfg_pkg::compliance_skp_bit];
            ltssm_compliance_deemph <=
                link_control2[vlink_cfg_pkg::compliance_deemph_bit];
            ltssm_compliance_deemph_valid <=
                link_control2[vlink_cfg_pkg::enter_compliance_bit];
            bar_zero_one_mode <= bar_mode;
            l0s_exit_ns       <= next_l0s_ns;
        end
    end

endmodule

// ===== testbench/vlink_cfg_props.sv
// Purpose: port-level checks of the virtual-side link register bank
// Assumes: one request at a time, answer one clock after the request
// Notes:   writes are compared two clocks on to allow a registered copy
`timescale 1ns/10ps
module vlink_cfg_props (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // configuration access
    input wire logic        cfg_req,
    input wire logic        cfg_write,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0]  cfg_be,
    input wire logic        cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // outputs watched
    input wire logic        ext_req,
    input wire logic        ltssm_insert_skp,
    input wire logic [1:0]  bar_zero_one_mode
);
    logic rd_req;
    logic wr_req;
    assign rd_req = cfg_req && !cfg_write;
    assign wr_req = cfg_req && cfg_write;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ****************************************
    // read data fields
    // ****************************************
    chk_status_rsvd_zero: assert property (
        rd_req && cfg_addr == vlink_cfg_pkg::off_link_status_control |=> cfg_ack
        && cfg_rdata[31:26] == 6'h0 && cfg_rdata[15:8] == 8'h00 && cfg_rdata[5:2] == 4'h0)
        else $error("link status reserved bits not zero");
    chk_cap_power_code: assert property (
        rd_req && cfg_addr == vlink_cfg_pkg::off_link_capability |=>
        cfg_rdata[11:10] == 2'h1 && cfg_rdata[23:18] == 6'h00)
        else $error("capability power field wrong");
    chk_vendor_header: assert property (
        rd_req && cfg_addr == vlink_cfg_pkg::off_vendor_cap_three_header |=>
        cfg_rdata == 32'h00380009) else $error("vendor header wrong");
    chk_subsys_upper: assert property (
        rd_req && cfg_addr == vlink_cfg_pkg::off_subsystem_cap_header |=>
        cfg_rdata[31:16] == 16'h0000) else $error("subsystem header upper bits set");
    chk_status2_rsvd: assert property (
        rd_req && cfg_addr == vlink_cfg_pkg::off_link_status_control_second |=>
        cfg_rdata[31:17] == 15'h0 && cfg_rdata[15:13] == 3'h0)
        else $error("second status reserved bits set");
    // ****************************************
    // control outputs
    // ****************************************
    chk_bar_mode_load: assert property (
        wr_req && cfg_addr == vlink_cfg_pkg::off_virtual_bar_zero_one_setup && cfg_be[0]
        && cfg_wdata[1:0] != 2'h1 |-> ##2 bar_zero_one_mode == $past(cfg_wdata[1:0], 2))
        else $error("bar mode not loaded");
    chk_bar_mode_keep: assert property (
        wr_req && cfg_addr == vlink_cfg_pkg::off_virtual_bar_zero_one_setup
        && cfg_wdata[1:0] == 2'h1 |=> $stable(bar_zero_one_mode) [*2])
        else $error("reserved bar code accepted");
    chk_skp_follow: assert property (
        wr_req && cfg_addr == vlink_cfg_pkg::off_link_status_control_second && cfg_be[1]
        |-> ##2 ltssm_insert_skp == $past(cfg_wdata[11], 2)) else $error("skp control wrong");
    chk_ext_cause: assert property (
        ext_req |-> $past(cfg_req) && $past(cfg_addr) == vlink_cfg_pkg::off_cursor_data)
        else $error("window access without request");
endmodule
bind virtual_side_link_config_regs vlink_cfg_props u_props (.clk_sys(clk_sys),
    .resetn(resetn), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .ext_req(ext_req), .ltssm_insert_skp(ltssm_insert_skp),
    .bar_zero_one_mode(bar_zero_one_mode));

// ===== testbench/test_virtual_side_link_config_regs.sv
// Purpose: self-checking bench for the virtual-side link register bank
// Assumes: straps settle before reset release, inputs move 1 ns after the edge
// Notes:   a second reset changes straps to reach port zero and low speed
`timescale 1ns/10ps
module test_virtual_side_link_config_regs;
    logic        clk_sys, resetn, speed_select_strap, preload_valid, link_up, link_at_gen2;
    logic        cfg_req, cfg_write, cfg_ack, ext_req, ext_write, ext_select_virtual;
    logic        ext_device_specific_ok, ltssm_insert_skp, ltssm_compliance_deemph;
    logic        ltssm_compliance_deemph_valid;
    logic [4:0]  station_lane_config_straps;
    logic [3:0]  nontransparent_port_select_straps, cfg_be;
    logic [5:0]  preload_max_width, link_width;
    logic [7:0]  preload_subsys_cap_id, preload_subsys_next_ptr, sync_nfts, async_nfts;
    logic [11:0] cfg_addr, ext_addr;
    logic [31:0] cfg_wdata, cfg_rdata, ext_wdata, ext_rdata, rd, ext_seen;
    logic [1:0]  bar_zero_one_mode;
    logic [12:0] l0s_exit_ns;
    int          failures, n_checks, cycles;
    logic [76:0] rows [20] = '{
        {1'h0, 12'h074, 32'h0, 32'h0A00C502}, {1'h0, 12'h078, 32'h0, 32'h00820000},
        {1'h0, 12'h098, 32'h0, 32'h00000002}, {1'h0, 12'h0A4, 32'h0, 32'h0000C80D},
        {1'h0, 12'h0C8, 32'h0, 32'h00380009}, {1'h0, 12'h0CC, 32'h0, 32'h03800002},
        {1'h0, 12'h0D0, 32'h0, 32'h00000002}, {1'h0, 12'h0A0, 32'h0, 32'h00000000},
        {1'h1, 12'h074, 32'hFFFFFFFF, 32'h0}, {1'h0, 12'h074, 32'h0, 32'h0A00C502},
        {1'h1, 12'h078, 32'hFFFFFFFF, 32'h0}, {1'h0, 12'h078, 32'h0, 32'h008200C3},
        {1'h1, 12'h098, 32'hFFFFFFFF, 32'h0}, {1'h0, 12'h098, 32'h0, 32'h00001F9F},
        {1'h1, 12'h0D0, 32'h00000001, 32'h0}, {1'h0, 12'h0D0, 32'h0, 32'h00000002},
        {1'h1, 12'h0D0, 32'hFFFFFFFF, 32'h0}, {1'h0, 12'h0D0, 32'h0, 32'h00000003},
        {1'h1, 12'h0F8, 32'h81230000, 32'h0}, {1'h0, 12'h0F8, 32'h0, 32'h81230000}};
    virtual_side_link_config_regs DUT (.clk_sys(clk_sys), .resetn(resetn),
        .speed_select_strap(speed_select_strap),
        .station_lane_config_straps(station_lane_config_straps),
        .nontransparent_port_select_straps(nontransparent_port_select_straps),
        .preload_valid(preload_valid), .preload_max_width(preload_max_width),
        .preload_subsys_cap_id(preload_subsys_cap_id),
        .preload_subsys_next_ptr(preload_subsys_next_ptr), .link_up(link_up),
        .link_at_gen2(link_at_gen2), .link_width(link_width), .sync_nfts(sync_nfts),
        .async_nfts(async_nfts), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .ext_req(ext_req), .ext_write(ext_write),
        .ext_select_virtual(ext_select_virtual), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_device_specific_ok(ext_device_specific_ok),
        .ext_rdata(ext_rdata), .ltssm_insert_skp(ltssm_insert_skp),
        .ltssm_compliance_deemph(ltssm_compliance_deemph),
        .ltssm_compliance_deemph_valid(ltssm_compliance_deemph_valid),
        .bar_zero_one_mode(bar_zero_one_mode), .l0s_exit_ns(l0s_exit_ns));
    // ****************************************
    // clock, timeout and tasks
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude;
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cfg_op(input logic w, input logic [11:0] a, input logic [31:0] d);
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge clk_sys);
        #1;
        check("ack", 32'h1, {31'h0, cfg_ack});
        rd = cfg_rdata;
        ext_seen = {16'h0, ext_write, ext_req, ext_select_virtual,
                    ext_device_specific_ok, ext_addr};
        cfg_req = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic do_reset;
        resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {resetn, cfg_req, cfg_write, preload_valid} = 4'h0;
        {speed_select_strap, link_up, link_at_gen2} = 3'h7;
        station_lane_config_straps = 5'h00;
        nontransparent_port_select_straps = 4'hA;
        {preload_max_width, preload_subsys_cap_id, preload_subsys_next_ptr} = 22'h13C5A;
        {link_width, sync_nfts, async_nfts, cfg_be} = {6'h08, 8'h40, 8'h40, 4'hF};
        {cfg_addr, cfg_wdata, ext_rdata} = {12'h0, 32'h0, 32'h5A3C96E1};
        do_reset();
        for (int i = 0; i < 20; i++) begin
            cfg_op(rows[i][76], rows[i][75:64], rows[i][63:32]);
            check($sformatf("row %0d", i), rows[i][31:0], rd);
        end
        check("ctl", 32'h7, {29'h0, ltssm_insert_skp, ltssm_compliance_deemph,
            ltssm_compliance_deemph_valid});
        check("bar", 32'h3, {30'h0, bar_zero_one_mode});
        async_nfts = 8'h28;
        repeat (2) @(posedge clk_sys);
        #1;
        check("l0s sync", 32'd512, {19'h0, l0s_exit_ns});
        cfg_op(1'b1, 12'h078, 32'h0);
        @(posedge clk_sys);
        #1;
        check("l0s async", 32'd320, {19'h0, l0s_exit_ns});
        cfg_op(1'b0, 12'h0FC, 32'h0);
        check("window", 32'h5A3C96E1, rd);
        check("ext", 32'h0000648C, ext_seen);
        cfg_op(1'b1, 12'h0FC, 32'hC3A55A3C);
        check("ext write", 32'h0000E48C, ext_seen);
        check("ext wdata", 32'hC3A55A3C, ext_wdata);
        preload_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        preload_valid = 1'b0;
        cfg_op(1'b0, 12'h074, 32'h0);
        check("preload width", 32'h0A00C412, rd);
        cfg_op(1'b0, 12'h0A4, 32'h0);
        check("preload hdr", 32'h00005A3C, rd);
        {speed_select_strap, link_up, link_at_gen2} = 3'h0;
        station_lane_config_straps = 5'h03;
        nontransparent_port_select_straps = 4'h0;
        do_reset();
        cfg_op(1'b0, 12'h074, 32'h0);
        check("cap low", 32'h00015421, rd);
        cfg_op(1'b0, 12'h078, 32'h0);
        check("status down", 32'h00010000, rd);
        cfg_op(1'b0, 12'h098, 32'h0);
        check("status2 low", 32'h00010002, rd);
        check("l0s gen1", 32'd640, {19'h0, l0s_exit_ns});
        cfg_op(1'b0, 12'h0FC, 32'h0);
        check("ext port0", 32'h00005000, ext_seen);
        conclude();
    end
endmodule
